// ### design/mcac_top.sv
// modem call answer sequencer for the remote diagnostic port, with axi4-lite registers
// Contract
// - keyswitch in offsite full access asserts dtr so the modem may answer
// - after dsr the device asserts rts
// - connection counts as established only after a valid protocol message
// - loss of cd starts termination and drops dtr
// - after termination dtr returns if keyswitch is in an offsite position
// - onsite keyswitch disables remote access and call answering
// - offsite full access gives the remote port control and lights the lamp
// - connected remote operator may boot, use console, program io, chat
// - remote port logic is independent of the local console terminal
// - keyswitch position readable in bits 0 and 1 of panel register
// - offsite program-io-only limits remote access to program io; boot and chat stay allowed there once connected
// - lamp lit in both offsite positions, dark in both onsite
`timescale 1ns/10ps
module mcac_top (
    input  wire logic                       clk_in,         // 40 MHz clock
    input  wire logic                       rst_n_in,       // async reset, active low
    input  wire logic [1:0]                 keyswitch_in,   // panel keyswitch pins
    input  wire mcac_pkg::mcac_modem_in_type modem_in,      // dsr, cd, cts from modem
    output mcac_pkg::mcac_modem_out_type    modem_out,         // dtr, rts to modem
    output logic                            remote_lamp_out,   // remote indicator lamp
    output logic                            remote_ctrl_out,   // remote port owns the system
    output logic                            console_io_en_out, // remote console io allowed
    output logic                            prog_io_en_out,    // remote program io allowed
    output logic                            chat_out,          // operator chat state active
    output logic                            boot_req_out,      // one-cycle remote boot pulse
    input  wire logic [7:0]                 s_axi_awaddr,   // write address
    input  wire logic                       s_axi_awvalid,  // write address valid
    output logic                            s_axi_awready,  // write address ready
    input  wire logic [31:0]                s_axi_wdata,    // write data
    input  wire logic [3:0]                 s_axi_wstrb,    // write strobes
    input  wire logic                       s_axi_wvalid,   // write data valid
    output logic                            s_axi_wready,   // write data ready
    output logic [1:0]                      s_axi_bresp,    // write response
    output logic                            s_axi_bvalid,   // write response valid
    input  wire logic                       s_axi_bready,   // write response ready
    input  wire logic [7:0]                 s_axi_araddr,   // read address
    input  wire logic                       s_axi_arvalid,  // read address valid
    output logic                            s_axi_arready,  // read address ready
    output logic [31:0]                     s_axi_rdata,    // read data
    output logic [1:0]                      s_axi_rresp,    // read response
    output logic                            s_axi_rvalid,   // read data valid
    input  wire logic                       s_axi_rready    // read data ready
);

    // two-flop synchronisers for pins; first stage read only by second
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end
        else
        begin
            sync_a <= {keyswitch_in, modem_in.dsr, modem_in.cd, modem_in.cts};
            sync_b <= sync_a;
        end
    end

    wire logic [1:0] key = sync_b[4:3];
    wire logic       dsr = sync_b[2];
    wire logic       cd  = sync_b[1];
    wire logic       cts = sync_b[0];

    wire logic key_full    = (key == mcac_pkg::KEY_REMOTE);
    wire logic key_prog    = (key == mcac_pkg::KEY_REMOTE_DIS);
    wire logic key_offsite = key_full | key_prog;

    // axi write: address and data latched independently, answered once both held
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take  = s_axi_wvalid & s_axi_wready;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    wire logic wr_fire   = aw_held & w_held & ~s_axi_bvalid;
    wire logic wr_ctrl   = wr_fire & (aw_addr == mcac_pkg::ADDR_CTRL) & w_strb[0];
    wire logic wr_ok     = (aw_addr == mcac_pkg::ADDR_CTRL);

    logic chat_req;
    wire logic msg_pulse  = wr_ctrl & w_data[mcac_pkg::CTRL_MSG_VALID];
    wire logic done_pulse = wr_ctrl & w_data[mcac_pkg::CTRL_TERM_DONE];

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mcac_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? mcac_pkg::RESP_OKAY : mcac_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // call sequencer
    mcac_pkg::mcac_state_type state;
    mcac_pkg::mcac_state_type next_state;
    logic connected;

    always_comb
    begin
        next_state = state;
        case (state)
            mcac_pkg::ST_IDLE:
                if (key_full)
                    next_state = mcac_pkg::ST_ARMED;
            mcac_pkg::ST_ARMED:
                if (!key_offsite)
                    next_state = mcac_pkg::ST_IDLE;
                else if (dsr)
                    next_state = mcac_pkg::ST_ANSWER;
            mcac_pkg::ST_ANSWER:
                if (!key_offsite)
                    next_state = mcac_pkg::ST_TERM;
                else if (cd && cts)
                    next_state = mcac_pkg::ST_CONNECT;
                else if (!dsr)
                    next_state = mcac_pkg::ST_TERM;
            mcac_pkg::ST_CONNECT:
                if (!cd || !key_offsite)
                    next_state = mcac_pkg::ST_TERM;
            mcac_pkg::ST_TERM:
                if (done_pulse)
                    next_state = key_offsite ? mcac_pkg::ST_ARMED
                                             : mcac_pkg::ST_IDLE;
            default:
                next_state = mcac_pkg::ST_IDLE;
        endcase
    end

    // dtr high only in armed, answering and connected; rts only after dsr
    wire logic next_dtr = (next_state == mcac_pkg::ST_ARMED) |
                          (next_state == mcac_pkg::ST_ANSWER) |
                          (next_state == mcac_pkg::ST_CONNECT);
    wire logic next_rts = (next_state == mcac_pkg::ST_ANSWER) |
                          (next_state == mcac_pkg::ST_CONNECT);

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state     <= mcac_pkg::ST_IDLE;
            modem_out <= '0;
            connected <= 1'b0;
            chat_req  <= 1'b0;
            boot_req_out <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            modem_out.dtr <= next_dtr;
            modem_out.rts <= next_rts;
            // message that coincides with a teardown is dropped: the call is gone
            connected     <= (next_state == mcac_pkg::ST_CONNECT) &
                             (connected | msg_pulse);
            if (wr_ctrl)
                chat_req <= w_data[mcac_pkg::CTRL_CHAT];
            boot_req_out  <= wr_ctrl & w_data[mcac_pkg::CTRL_BOOT] & connected;
        end
    end

    // remote modes; local console settings are not touched here
    assign remote_lamp_out   = key_offsite;
    assign remote_ctrl_out   = key_full & connected;
    assign console_io_en_out = key_full & connected;
    assign prog_io_en_out    = key_offsite & connected;
    assign chat_out          = chat_req & connected;

    // axi read
    wire logic [31:0] rd_status = {24'h00_0000, connected, state == mcac_pkg::ST_TERM,
                                   modem_out.dtr, modem_out.rts, dsr, cd, cts, 1'b0};
    wire logic [31:0] rd_panel  = {30'h0000_0000, key};
    wire logic rd_hit = (s_axi_araddr == mcac_pkg::ADDR_PANEL) |
                        (s_axi_araddr == mcac_pkg::ADDR_CTRL) |
                        (s_axi_araddr == mcac_pkg::ADDR_STATUS);
    wire logic [31:0] rd_mux =
        (s_axi_araddr == mcac_pkg::ADDR_PANEL)  ? rd_panel :
        (s_axi_araddr == mcac_pkg::ADDR_STATUS) ? rd_status :
        (s_axi_araddr == mcac_pkg::ADDR_CTRL)   ? {28'h000_0000, 1'b0, chat_req, 2'h0} :
                                                  32'h0000_0000;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= mcac_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? mcac_pkg::RESP_OKAY : mcac_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ### dv/mcac_modem_model.sv
// behavioural auto-answer modem facing the sequencer
`timescale 1ns/10ps
module mcac_modem_model (
    input  wire logic                         clk_in,   // clock
    input  wire logic                         ring_in,  // incoming call present
    input  wire logic                         lost_in,  // remote carrier gone
    input  wire logic [2:0]                   delay_in, // extra cycles per step
    input  wire mcac_pkg::mcac_modem_out_type ctl_in,   // dtr rts
    output mcac_pkg::mcac_modem_in_type       lines_out // dsr cd cts
);
    logic [2:0] cnt;
    always_ff @(posedge clk_in)
    begin
        if (!ctl_in.dtr)
        begin
            lines_out <= '0;
            cnt <= 3'h0;
        end
        else if (lost_in)
        begin
            lines_out.cd  <= 1'b0;
            lines_out.cts <= 1'b0;
        end
        else if (cnt != delay_in)
            cnt <= cnt + 3'h1;
        else
        begin
            cnt <= 3'h0;
            lines_out.dsr <= lines_out.dsr | ring_in;
            lines_out.cd  <= lines_out.cd | (ctl_in.rts & lines_out.dsr);
            lines_out.cts <= lines_out.cts | lines_out.cd;
        end
    end
endmodule

// ### dv/mcac_properties.sv
// concurrent checks on the call answer sequencer ports
`timescale 1ns/10ps
module mcac_properties (
    input wire logic                         clk_in,            // clock
    input wire logic                         rst_n_in,          // reset, active low
    input wire logic [1:0]                   keyswitch_in,      // key pins
    input wire mcac_pkg::mcac_modem_in_type  modem_in,          // dsr cd cts
    input wire mcac_pkg::mcac_modem_out_type modem_out,         // dtr rts
    input wire logic                         remote_lamp_out,   // lamp
    input wire logic                         remote_ctrl_out,   // remote control
    input wire logic                         console_io_en_out, // console io
    input wire logic                         prog_io_en_out,    // program io
    input wire logic                         chat_out,          // chat state
    input wire logic                         boot_req_out       // boot pulse
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // the key passes two sync flops and one register before dtr moves
    sequence s_onsite;
        !keyswitch_in[1] [*4];
    endsequence
    sequence s_key3;
        (keyswitch_in == 2'h3) [*4];
    endsequence
    a_lamp_key: assert property ($stable(keyswitch_in) [*3] |->
        remote_lamp_out == keyswitch_in[1]) else $error("lamp does not follow key");
    a_onsite_off: assert property (s_onsite |-> !modem_out.dtr && !prog_io_en_out)
        else $error("remote access while onsite");
    a_key3_limit: assert property (s_key3 |-> !console_io_en_out)
        else $error("console io in program-io-only");
    a_rts_dtr: assert property (modem_out.rts |-> modem_out.dtr)
        else $error("rts without dtr");
    a_rts_dsr: assert property ($rose(modem_out.rts) |-> $past(modem_in.dsr, 2))
        else $error("rts before dsr");
    a_cd_loss: assert property ($fell(modem_in.cd) && prog_io_en_out |->
        ##[1:4] !modem_out.dtr) else $error("dtr kept after carrier loss");
    a_ctrl_full: assert property (remote_ctrl_out |->
        remote_lamp_out && prog_io_en_out && modem_out.dtr)
        else $error("remote control outside a full access call");
    // connected is only held in the call state, where both modem lines are up
    a_chat_conn: assert property (chat_out |-> modem_out.dtr && modem_out.rts)
        else $error("chat outside connection");
    a_boot_pulse: assert property (boot_req_out |=> !boot_req_out)
        else $error("boot pulse too long");
endmodule
bind mcac_top mcac_properties u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .keyswitch_in(keyswitch_in), .modem_in(modem_in), .modem_out(modem_out),
    .remote_lamp_out(remote_lamp_out), .remote_ctrl_out(remote_ctrl_out),
    .console_io_en_out(console_io_en_out), .prog_io_en_out(prog_io_en_out),
    .chat_out(chat_out), .boot_req_out(boot_req_out));

// ### dv/mcac_top_tb_top.sv
// self-checking bench for the call answer sequencer
`timescale 1ns/10ps
module mcac_top_tb_top;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, ring = 1'b0, lost = 1'b0;
    logic [1:0]  key = 2'h0, k, bresp, rresp;
    logic [2:0]  dly = 3'h0;
    logic [3:0]  wstrb = 4'hf;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, lamp, rctl, cio, pio, chat, boot;
    logic [34:0] ent, exp_q [$];
    int          miscompares = 0, n_compared = 0, cyc = 0, boots = 0;
    mcac_pkg::mcac_modem_in_type  mi;
    mcac_pkg::mcac_modem_out_type mo;
    always #12.5 clk_in = ~clk_in;
    mcac_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .keyswitch_in(key), .modem_in(mi),
        .modem_out(mo), .remote_lamp_out(lamp), .remote_ctrl_out(rctl),
        .console_io_en_out(cio), .prog_io_en_out(pio), .chat_out(chat), .boot_req_out(boot),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    mcac_modem_model u_modem (.clk_in(clk_in), .ring_in(ring), .lost_in(lost),
        .delay_in(dly), .ctl_in(mo), .lines_out(mi));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({1'b0, r, 32'h0000_0000});
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clk_in);
        bready <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r == mcac_pkg::RESP_OKAY, r, d});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk_in); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk_in);
        rready <= 1'b0;
        @(posedge clk_in);
    endtask
    // the monitor pairs each bus answer with the oldest expectation
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            wrap_up();
        end
        if (boot === 1'b1) boots++;
        if ((bvalid && bready) || (rvalid && rready))
        begin
            ent = exp_q.pop_front();
            check("resp", bvalid ? bresp : rresp, ent[33:32]);
            if (ent[34]) check("rdata", rdata, ent[31:0]);
        end
    end
    initial
    begin
        void'($urandom(32'h6011));
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        dly <= 3'($urandom_range(7));
        for (int i = 0; i < 4; i++)
        begin
            k = {i[1], i[1] ^ i[0]};
            key <= k;
            repeat (5) @(posedge clk_in);
            check("lamp", lamp, k[1]);
            check("dtr", mo.dtr, k == mcac_pkg::KEY_REMOTE);
            rd(mcac_pkg::ADDR_PANEL, {30'h0000_0000, k}, mcac_pkg::RESP_OKAY);
        end
        rd(8'h0c, 32'h0000_0000, mcac_pkg::RESP_SLVERR);
        wr(mcac_pkg::ADDR_PANEL, 32'h0000_0003, mcac_pkg::RESP_SLVERR);
        wr(mcac_pkg::ADDR_CTRL, 32'h0000_0001, mcac_pkg::RESP_OKAY);
        rd(mcac_pkg::ADDR_STATUS, 32'h0000_0020, mcac_pkg::RESP_OKAY);
        ring <= 1'b1;
        repeat (64) if (!mi.cts) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
        check("rts", {mo.rts, pio}, 2'h2);
        rd(mcac_pkg::ADDR_STATUS, 32'h0000_003e, mcac_pkg::RESP_OKAY);
        wr(mcac_pkg::ADDR_CTRL, 32'h0000_0001, mcac_pkg::RESP_OKAY);
        rd(mcac_pkg::ADDR_STATUS, 32'h0000_00be, mcac_pkg::RESP_OKAY);
        check("access", {rctl, cio, pio}, 3'h7);
        // lane 0 off: this control write must neither chat nor boot
        wstrb <= 4'he;
        wr(mcac_pkg::ADDR_CTRL, 32'h0000_000c, mcac_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        wr(mcac_pkg::ADDR_CTRL, 32'h0000_000c, mcac_pkg::RESP_OKAY);
        rd(mcac_pkg::ADDR_CTRL, 32'h0000_0004, mcac_pkg::RESP_OKAY);
        check("chat", {chat, boots[1:0]}, 3'h5);
        key <= mcac_pkg::KEY_REMOTE_DIS;
        repeat (5) @(posedge clk_in);
        check("io", {cio, pio}, 2'h1);
        lost <= 1'b1;
        repeat (16) if (mo.dtr) @(posedge clk_in);
        check("drop", {mo.dtr, mo.rts}, 2'h0);
        ring <= 1'b0;
        lost <= 1'b0;
        repeat (4) @(posedge clk_in);
        rd(mcac_pkg::ADDR_STATUS, 32'h0000_0040, mcac_pkg::RESP_OKAY);
        wr(mcac_pkg::ADDR_CTRL, 32'h0000_0002, mcac_pkg::RESP_OKAY);
        repeat (4) @(posedge clk_in);
        check("rearm", mo.dtr, 1'b1);
        key <= mcac_pkg::KEY_LOCAL;
        repeat (5) @(posedge clk_in);
        check("onsite", {mo.dtr, lamp}, 2'h0);
        wrap_up();
    end
endmodule

// ### shared/mcac_pkg.sv
// package for the modem call answer control block: register map, fields, states
package mcac_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_PANEL  = 8'h00;  // misc_panel_control_status (read only)
    localparam logic [7:0] ADDR_CTRL   = 8'h04;  // control written by the console processor
    localparam logic [7:0] ADDR_STATUS = 8'h08;  // modem lines and call state (read only)

    // keyswitch codes in bits 1:0 of the panel register
    localparam logic [1:0] KEY_LOCAL      = 2'h0;
    localparam logic [1:0] KEY_LOCAL_DIS  = 2'h1;
    localparam logic [1:0] KEY_REMOTE     = 2'h2;
    localparam logic [1:0] KEY_REMOTE_DIS = 2'h3;

    // control register fields
    localparam int CTRL_MSG_VALID = 0;  // write 1: valid protocol message received
    localparam int CTRL_TERM_DONE = 1;  // write 1: termination sequence finished
    localparam int CTRL_CHAT      = 2;  // operator chat state requested
    localparam int CTRL_BOOT      = 3;  // remote boot request

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_ARMED   = 5'b00010,
        ST_ANSWER  = 5'b00100,
        ST_CONNECT = 5'b01000,
        ST_TERM    = 5'b10000
    } mcac_state_type;

    // modem lines from the modem
    typedef struct packed {
        logic dsr;
        logic cd;
        logic cts;
    } mcac_modem_in_type;

    // modem lines to the modem
    typedef struct packed {
        logic dtr;
        logic rts;
    } mcac_modem_out_type;

endpackage
